// file: design/ctmr_pkg.sv
// package: register map, field layout and modes of the dual counter/timer
// assumes one bus clock; registers reached over a 32-bit apb slave
package ctmr_pkg;
   localparam int unsigned INST_NUM = 2;
   localparam int unsigned CAP_NUM  = 2;
   localparam int unsigned MAT_NUM  = 4;
   localparam int unsigned MOUT_NUM = 2;
   localparam int unsigned DMA_NUM  = 2;

   // per-instance window: instance n at n * INST_STRIDE
   localparam logic [11:0] INST_STRIDE  = 12'h0100;
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_COUNT    = 8'h04;
   localparam logic [7:0]  OFF_PRE_MAX  = 8'h08;
   localparam logic [7:0]  OFF_PRE_CNT  = 8'h0C;
   localparam logic [7:0]  OFF_MAT_CTRL = 8'h10;
   localparam logic [7:0]  OFF_CAP_CTRL = 8'h14;
   localparam logic [7:0]  OFF_OUT_CTRL = 8'h18;
   localparam logic [7:0]  OFF_STATUS   = 8'h1C;
   localparam logic [7:0]  OFF_MASK     = 8'h20;
   localparam logic [7:0]  OFF_MAT0     = 8'h30;
   localparam logic [7:0]  OFF_CAP0     = 8'h40;

   // ctrl fields
   localparam int unsigned CTRL_EN      = 0;
   localparam int unsigned CTRL_RST     = 1;
   localparam int unsigned CTRL_SRC     = 2;  // 2 bits
   localparam int unsigned CTRL_CLRSEL  = 4;  // 2 bits: 0 off, 1 ch0, 2 ch1
   localparam int unsigned CTRL_CLRRISE = 6;  // 1 rise, 0 fall

   // match ctrl: 3 bits per match: int, reset, stop
   localparam int unsigned MAT_FLD   = 3;
   localparam int unsigned MAT_INT   = 0;
   localparam int unsigned MAT_RESET = 1;
   localparam int unsigned MAT_STOP  = 2;
   // capture ctrl: 3 bits per channel: rise, fall, int
   localparam int unsigned CAP_FLD  = 3;
   localparam int unsigned CAP_RISE = 0;
   localparam int unsigned CAP_FALL = 1;
   localparam int unsigned CAP_INT  = 2;
   // out ctrl: 2 bits action per output, state bits at OUT_STATE
   localparam int unsigned OUT_FLD   = 2;
   localparam int unsigned OUT_STATE = 8;
   // status/mask: matches in [3:0], captures in [5:4]
   localparam int unsigned ST_CAP = 4;
   localparam int unsigned ST_W   = 6;

   typedef enum logic [1:0] {SRC_BUSCLK, SRC_CAP_RISE, SRC_CAP_FALL, SRC_CAP_BOTH} src_t;
   typedef enum logic [1:0] {OUT_HOLD, OUT_LOW, OUT_HIGH, OUT_TOGGLE} out_act_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic                pwr;   // write strobe at access edge
      logic [7:0]          off;
      logic [31:0]         data;
   } reg_wr_t;
endpackage : ctmr_pkg

// file: design/ctmr_core.sv
// one counter/timer instance: prescaler, count, captures, matches, outputs
// assumes capture inputs synchronous to clk_i; register writes arrive as reg_wr_t strobes
`timescale 1ns/1ps
module ctmr_core
   import ctmr_pkg::*;
#(
   parameter int unsigned CNT_W = 32
) (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  reset_i,
   // register access
   input  wire reg_wr_t               wr_i,
   input  wire logic [7:0]            rd_off_i,
   output logic      [31:0]           rd_data_o,
   // pins
   input  wire logic [CAP_NUM-1:0]    cap_i,
   output logic      [MOUT_NUM-1:0]   mat_out_o,
   // events
   output logic                       irq_o,
   output logic      [DMA_NUM-1:0]    dma_req_o
);
   logic [31:0]          ctrl_r;
   logic [CNT_W-1:0]     timer_count_value_r;
   logic [CNT_W-1:0]     pre_max_r, pre_cnt_r;
   logic [31:0]          mat_ctrl_r, cap_ctrl_r, out_ctrl_r;
   logic [ST_W-1:0]      status_r, mask_r;
   logic [CNT_W-1:0]     mat_r [MAT_NUM];
   logic [CNT_W-1:0]     cap_r [CAP_NUM];
   logic [CAP_NUM-1:0]   cap_q_r;
   logic [MOUT_NUM-1:0]  mout_r;
   logic [MAT_NUM-1:0]   hit_r;
   logic [CAP_NUM-1:0]   cap_rise, cap_fall, cap_ev;
   logic [MAT_NUM-1:0]   hit, hit_new;
   logic                 tick, clr_ev, stop_ev, reset_ev;
   logic [ST_W-1:0]      st_set;
   logic [1:0]           clr_sel;
   src_t                 src;

   function automatic logic is_wr(input reg_wr_t w, input logic [7:0] o);
      return w.pwr && (w.off == o);
   endfunction : is_wr

   ////////////////////////////////////////////////////////////////////////
   // capture edges and count source
   assign cap_rise = cap_i & ~cap_q_r;
   assign cap_fall = ~cap_i & cap_q_r;
   assign src      = src_t'(ctrl_r[CTRL_SRC +: 2]);
   assign clr_sel  = ctrl_r[CTRL_CLRSEL +: 2];

   always_comb begin
      tick = 1'b0;
      unique case (src)
         SRC_BUSCLK:   tick = 1'b1;
         SRC_CAP_RISE: tick = cap_rise[0];
         SRC_CAP_FALL: tick = cap_fall[0];
         SRC_CAP_BOTH: tick = cap_rise[0] | cap_fall[0];
      endcase
      // a stopping match swallows its own tick so the count rests on the match value
      tick = tick & ctrl_r[CTRL_EN] & ~ctrl_r[CTRL_RST] & ~stop_ev;
   end

   genvar g;
   generate
      for (g = 0; g < CAP_NUM; g++) begin : g_cap
         // one pin per channel
         assign cap_ev[g] = (cap_rise[g] & cap_ctrl_r[g*CAP_FLD+CAP_RISE])
                          | (cap_fall[g] & cap_ctrl_r[g*CAP_FLD+CAP_FALL]);
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               cap_r[g] <= '0;
            end else if (cap_ev[g]) begin
               cap_r[g] <= timer_count_value_r;
            end
         end
      end
      for (g = 0; g < MAT_NUM; g++) begin : g_mat
         assign hit[g] = (timer_count_value_r == mat_r[g]);
      end
   endgenerate

   assign clr_ev = (clr_sel == 2'd1 || clr_sel == 2'd2) && (ctrl_r[CTRL_CLRRISE]
                   ? cap_rise[clr_sel[1]] : cap_fall[clr_sel[1]]);
   assign hit_new  = hit & ~hit_r;
   always_comb begin
      stop_ev  = 1'b0;
      reset_ev = 1'b0;
      for (int i = 0; i < MAT_NUM; i++) begin
         stop_ev  = stop_ev  | (hit_new[i] & mat_ctrl_r[i*MAT_FLD+MAT_STOP]);
         reset_ev = reset_ev | (hit[i] & mat_ctrl_r[i*MAT_FLD+MAT_RESET]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counting
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         // count and match registers both reset to zero: no match event out of reset
         hit_r   <= '1;
         cap_q_r <= '0;
      end else begin
         hit_r   <= hit;
         cap_q_r <= cap_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         timer_count_value_r <= '0;
         pre_cnt_r           <= '0;
      end else if (ctrl_r[CTRL_RST] || clr_ev) begin
         timer_count_value_r <= '0;
         pre_cnt_r           <= '0;
      end else if (is_wr(wr_i, OFF_COUNT)) begin
         timer_count_value_r <= wr_i.data[CNT_W-1:0];
      end else if (tick) begin
         if (pre_cnt_r >= pre_max_r) begin
            pre_cnt_r           <= '0;
            timer_count_value_r <= reset_ev ? '0 : timer_count_value_r + 1'b1;
         end else begin
            pre_cnt_r <= pre_cnt_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctrl_r     <= '0;
         pre_max_r  <= '0;
         mat_ctrl_r <= '0;
         cap_ctrl_r <= '0;
         mask_r     <= '0;
         for (int i = 0; i < MAT_NUM; i++) mat_r[i] <= '0;
      end else begin
         if (is_wr(wr_i, OFF_CTRL))     ctrl_r     <= wr_i.data;
         else if (stop_ev)              ctrl_r[CTRL_EN] <= 1'b0;
         if (is_wr(wr_i, OFF_PRE_MAX))  pre_max_r  <= wr_i.data[CNT_W-1:0];
         if (is_wr(wr_i, OFF_MAT_CTRL)) mat_ctrl_r <= wr_i.data;
         if (is_wr(wr_i, OFF_CAP_CTRL)) cap_ctrl_r <= wr_i.data;
         if (is_wr(wr_i, OFF_MASK))     mask_r     <= wr_i.data[ST_W-1:0];
         for (int i = 0; i < MAT_NUM; i++) begin
            if (is_wr(wr_i, OFF_MAT0 + 8'(4*i))) mat_r[i] <= wr_i.data[CNT_W-1:0];
         end
      end
   end

   always_comb begin
      st_set = '0;
      for (int i = 0; i < MAT_NUM; i++) begin
         st_set[i] = hit_new[i] & mat_ctrl_r[i*MAT_FLD+MAT_INT];
      end
      for (int i = 0; i < CAP_NUM; i++) begin
         st_set[ST_CAP+i] = cap_ev[i] & cap_ctrl_r[i*CAP_FLD+CAP_INT];
      end
   end

   // sticky status: set beats write-one-to-clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         status_r <= '0;
      end else begin
         for (int i = 0; i < ST_W; i++) begin
            if (st_set[i]) status_r[i] <= 1'b1;
            else if (is_wr(wr_i, OFF_STATUS) && wr_i.data[i]) status_r[i] <= 1'b0;
         end
      end
   end
   assign irq_o = |(status_r & mask_r);

   ////////////////////////////////////////////////////////////////////////
   // match outputs and dma requests
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         out_ctrl_r <= '0;
         mout_r     <= '0;
      end else if (is_wr(wr_i, OFF_OUT_CTRL)) begin
         out_ctrl_r <= wr_i.data;
         mout_r     <= wr_i.data[OUT_STATE +: MOUT_NUM];
      end else begin
         for (int i = 0; i < MOUT_NUM; i++) begin
            if (hit_new[i]) begin
               unique case (out_act_t'(out_ctrl_r[i*OUT_FLD +: OUT_FLD]))
                  OUT_HOLD:   mout_r[i] <= mout_r[i];
                  OUT_LOW:    mout_r[i] <= 1'b0;
                  OUT_HIGH:   mout_r[i] <= 1'b1;
                  OUT_TOGGLE: mout_r[i] <= ~mout_r[i];
               endcase
            end
         end
      end
   end
   assign mat_out_o = mout_r;
   assign dma_req_o = hit_new[DMA_NUM-1:0];

   always_comb begin
      rd_data_o = '0;
      unique case (rd_off_i)
         OFF_CTRL:     rd_data_o = ctrl_r;
         OFF_COUNT:    rd_data_o = 32'(timer_count_value_r);
         OFF_PRE_MAX:  rd_data_o = 32'(pre_max_r);
         OFF_PRE_CNT:  rd_data_o = 32'(pre_cnt_r);
         OFF_MAT_CTRL: rd_data_o = mat_ctrl_r;
         OFF_CAP_CTRL: rd_data_o = cap_ctrl_r;
         OFF_OUT_CTRL: rd_data_o = {out_ctrl_r[31:OUT_STATE+MOUT_NUM], mout_r,
                                    out_ctrl_r[OUT_STATE-1:0]};
         OFF_STATUS:   rd_data_o = 32'(status_r);
         OFF_MASK:     rd_data_o = 32'(mask_r);
         default: begin
            for (int i = 0; i < MAT_NUM; i++)
               if (rd_off_i == OFF_MAT0 + 8'(4*i)) rd_data_o = 32'(mat_r[i]);
            for (int i = 0; i < CAP_NUM; i++)
               if (rd_off_i == OFF_CAP0 + 8'(4*i)) rd_data_o = 32'(cap_r[i]);
         end
      endcase
   end
endmodule : ctmr_core

// file: design/ctmr_top.sv
// top: two counter/timer instances behind one apb slave
// assumes apb master on clk_i; pins synchronous to clk_i
//
// How it works
// - two identical, independent counter/timer instances
// - 32-bit count advanced through programmable 32-bit prescaler
// - timer mode counts bus clocks, counter mode counts external clock
// - capture input 0 may be chosen as count source
// - two capture channels copy count on configured input transition
// - each capture channel may raise an interrupt flag
// - each capture channel fed by exactly one capture pin
// - selected capture edge clears count and prescaler
// - four 32-bit match registers compared continuously with count
// - match may keep counting with optional interrupt
// - match may stop the counter with optional interrupt
// - match may reset the count to zero with optional interrupt
// - two match outputs go low, high, toggle or hold on match
// - two matches issue dma requests
`timescale 1ns/1ps
module ctmr_top
   import ctmr_pkg::*;
#(
   parameter int unsigned CNT_W = 32
) (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          reset_i,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [11:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic      [31:0]                   prdata,
   // pins
   input  wire logic [INST_NUM*CAP_NUM-1:0]   cap_i,
   output logic      [INST_NUM*MOUT_NUM-1:0]  mat_out_o,
   // events
   output logic      [INST_NUM-1:0]           irq_o,
   output logic      [INST_NUM*DMA_NUM-1:0]   dma_req_o
);
   logic [31:0]         rd [INST_NUM];
   logic                acc, inst_sel;
   reg_wr_t             wr [INST_NUM];

   assign acc      = psel & penable;
   assign inst_sel = paddr[8];
   assign pready   = 1'b1;
   assign pslverr  = acc & ((paddr[11:9] != 3'h0) | (paddr[1:0] != 2'h0));

   genvar g;
   generate
      for (g = 0; g < INST_NUM; g++) begin : g_inst
         assign wr[g].pwr  = acc & pwrite & ~pslverr & (inst_sel == 1'(g));
         assign wr[g].off  = paddr[7:0];
         assign wr[g].data = pwdata;
         ctmr_core #(.CNT_W(CNT_W)) u_core (
            .clk_i     (clk_i),
            .reset_i   (reset_i),
            .wr_i      (wr[g]),
            .rd_off_i  (paddr[7:0]),
            .rd_data_o (rd[g]),
            .cap_i     (cap_i[g*CAP_NUM +: CAP_NUM]),
            .mat_out_o (mat_out_o[g*MOUT_NUM +: MOUT_NUM]),
            .irq_o     (irq_o[g]),
            .dma_req_o (dma_req_o[g*DMA_NUM +: DMA_NUM])
         );
      end
   endgenerate

   assign prdata = (acc & ~pwrite & ~pslverr) ? rd[inst_sel] : 32'h0000_0000;
endmodule : ctmr_top

// file: verification/ctmr_chk_sva.sv
// checker: bus and event-output relations at the ctmr_top ports
// assumes a bind onto ctmr_top; a single clock domain
`timescale 1ns/1ps
module ctmr_chk
   import ctmr_pkg::*;
#(
   parameter int unsigned CNT_W = 32
) (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        reset_i,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // pins and events
   input wire logic [3:0]  cap_i,
   input wire logic [3:0]  mat_out_o,
   input wire logic [1:0]  irq_o,
   input wire logic [3:0]  dma_req_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   wire logic acc = psel && penable;
////////////////////
   chk_ready_high: assert property (acc |-> pready)
      else $error("pready low in access");
   chk_bad_addr: assert property (acc && paddr[11:9] != 3'h0 |-> pslverr)
      else $error("no error on bad address");
   chk_good_addr: assert property (acc && paddr[11:9] == 3'h0 && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("error on good address");
   chk_rdata_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read");
   chk_unmapped_zero: assert property (acc && !pwrite && paddr == 12'h024
      |-> prdata == 32'h0) else $error("unmapped read not zero");
   chk_dma_single: assert property ((dma_req_o & $past(dma_req_o)) == 4'h0)
      else $error("dma request longer than one cycle");
   chk_quiet_start: assert property ($fell(reset_i) |->
      irq_o == 2'h0 && dma_req_o == 4'h0 && mat_out_o == 4'h0) else $error("outputs after reset");
   chk_mask_off: assert property (acc && pwrite && paddr == {4'h0, OFF_MASK}
      && pwdata[5:0] == 6'h00 |=> !irq_o[0] [*2]) else $error("irq with mask clear");
   cov_dma: cover property (dma_req_o[0]);
   cov_irq: cover property ($rose(irq_o[1]));
   cov_out: cover property ($changed(mat_out_o));
endmodule : ctmr_chk

// file: verification/cap_pin_model.sv
// model: external capture pins of both instances
// assumes pins sampled on clk_i; a pulse spans three clocks
`timescale 1ns/1ps
module cap_pin_model
   import ctmr_pkg::*;
(
   // clock
   input wire logic                        clk_i,
   // pins
   output logic [INST_NUM*CAP_NUM-1:0]     cap_o
);
   initial cap_o = '0;
   // one pin per channel, driven only by this model
   task automatic pulse(input int b);
      @(posedge clk_i);
      cap_o[b] <= 1'b1;
      repeat (3) @(posedge clk_i);
      cap_o[b] <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : pulse
endmodule : cap_pin_model

// file: verification/tb_capture_match_counter_timer.sv
// testbench: apb scenarios on both counter/timer instances
// assumes ctmr_top, cap_pin_model and ctmr_chk compiled before
`timescale 1ns/1ps
module tb_capture_match_counter_timer;
   import ctmr_pkg::*;
   localparam logic [3:0] I0 = 4'h0;
   localparam logic [3:0] I1 = 4'h1;
   logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  cap_i, mat_out_o, dma_req_o;
   logic [1:0]  irq_o;
   int          errors, comparisons, n;
   ctmr_top #(.CNT_W(32)) DUT (.clk_i(clk_i), .reset_i(reset_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .cap_i(cap_i), .mat_out_o(mat_out_o),
      .irq_o(irq_o), .dma_req_o(dma_req_o));
   cap_pin_model u_pins (.clk_i(clk_i), .cap_o(cap_i));
////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t ns: saw %h, want %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask : apb
   task automatic wr(input logic [3:0] i, input logic [7:0] o, input logic [31:0] d);
      apb(1'b1, {i, o}, d);
   endtask : wr
   task automatic rc(input logic [3:0] i, input logic [7:0] o, input logic [31:0] e);
      apb(1'b0, {i, o}, 32'h0);
      check(rd, e);
   endtask : rc
   task automatic give_verdict();
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
////////////////////
   task automatic t_reset();
      rc(I0, OFF_CTRL, 32'h0);
      rc(I1, OFF_COUNT, 32'h0);
      wr(I0, 8'h24, 32'hFFFF_FFFF);
      rc(I0, 8'h24, 32'h0);
      apb(1'b1, 12'h200, 32'h0000_0001);
   endtask : t_reset
   task automatic t_match();
      wr(I0, OFF_PRE_MAX, 32'h0000_0003);
      wr(I0, OFF_MAT_CTRL, 32'h0000_0001);
      wr(I0, OFF_MAT0, 32'h0000_0005);
      wr(I0, OFF_MAT0 + 8'h04, 32'h0000_0006);
      wr(I0, OFF_MASK, 32'h0000_0001);
      wr(I0, OFF_CTRL, 32'h0000_0001);
      n = 0;
      while (dma_req_o[0] !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (dma_req_o[1] !== 1'b1 && n < 200);
      check(n, 4);
      check(irq_o[0], 1'b1);
      wr(I0, OFF_STATUS, 32'h0000_0001);
      check(irq_o[0], 1'b0);
      wr(I0, OFF_MASK, 32'h0);
      wr(I0, OFF_CTRL, 32'h0);
      rc(I1, OFF_COUNT, 32'h0);
   endtask : t_match
   task automatic t_stop();
      wr(I0, OFF_COUNT, 32'h0);
      wr(I0, OFF_PRE_MAX, 32'h0);
      wr(I0, OFF_MAT_CTRL, 32'h0000_0140);
      wr(I0, OFF_MAT0 + 8'h08, 32'h0000_0007);
      wr(I0, OFF_STATUS, 32'h0000_003F);
      wr(I0, OFF_MASK, 32'h0000_0004);
      wr(I0, OFF_CTRL, 32'h0000_0001);
      repeat (20) @(posedge clk_i);
      check(irq_o[0], 1'b1);
      rc(I0, OFF_CTRL, 32'h0);
      rc(I0, OFF_COUNT, 32'h0000_0007);
      wr(I0, OFF_MASK, 32'h0);
   endtask : t_stop
   task automatic t_wrap();
      wr(I0, OFF_MAT_CTRL, 32'h0000_0400);
      wr(I0, OFF_MAT0 + 8'h0C, 32'h0000_0003);
      wr(I0, OFF_COUNT, 32'h0);
      wr(I0, OFF_CTRL, 32'h0000_0001);
      for (int k = 0; k < 8; k++) begin
         apb(1'b0, {I0, OFF_COUNT}, 32'h0);
         check(rd <= 32'h3, 1'b1);
      end
   endtask : t_wrap
   task automatic t_outs();
      logic [1:0] a;
      for (int k = 0; k < 4; k++) begin
         a = k[1:0];
         wr(I0, OFF_CTRL, 32'h0);
         wr(I0, OFF_COUNT, 32'h0);
         wr(I0, OFF_OUT_CTRL, {23'h0, a != OUT_HIGH, 6'h0, a});
         wr(I0, OFF_MAT_CTRL, 32'h0000_0004);
         wr(I0, OFF_MAT0, 32'h0000_0002);
         wr(I0, OFF_CTRL, 32'h0000_0001);
         repeat (10) @(posedge clk_i);
         check(mat_out_o[0], a == OUT_HIGH || a == OUT_HOLD);
      end
   endtask : t_outs
   task automatic t_capture();
      wr(I1, OFF_COUNT, 32'h0000_1234);
      wr(I1, OFF_CAP_CTRL, 32'h0000_0005);
      wr(I1, OFF_MASK, 32'h0000_0010);
      u_pins.pulse(2);
      rc(I1, OFF_CAP0, 32'h0000_1234);
      check(irq_o[1], 1'b1);
      wr(I1, OFF_STATUS, 32'h0000_0010);
      check(irq_o[1], 1'b0);
      wr(I1, OFF_CAP_CTRL, 32'h0000_0010);
      wr(I1, OFF_CTRL, 32'h0000_0061);
      wr(I1, OFF_COUNT, 32'h0000_0050);
      u_pins.pulse(3);
      apb(1'b0, {I1, OFF_CAP0 + 8'h04}, 32'h0);
      check(rd >= 32'h2 && rd <= 32'h4, 1'b1);
   endtask : t_capture
   task automatic t_source();
      // hold-reset first: the bus-clock count left running must not move count or prescaler
      wr(I1, OFF_CTRL, 32'h0000_0002);
      wr(I1, OFF_CAP_CTRL, 32'h0);
      wr(I1, OFF_PRE_MAX, 32'h0000_0001);
      wr(I1, OFF_COUNT, 32'h0);
      wr(I1, OFF_CTRL, 32'h0000_0005);
      repeat (4) u_pins.pulse(2);
      rc(I1, OFF_COUNT, 32'h0000_0002);
      wr(I1, OFF_CTRL, 32'h0);
   endtask : t_source
////////////////////
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      give_verdict();
   end
   initial begin
      reset_i = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_match();
      t_stop();
      t_wrap();
      t_outs();
      t_capture();
      t_source();
      give_verdict();
   end
endmodule : tb_capture_match_counter_timer

bind ctmr_top ctmr_chk #(.CNT_W(CNT_W)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .prdata(prdata), .cap_i(cap_i),
   .mat_out_o(mat_out_o), .irq_o(irq_o), .dma_req_o(dma_req_o));
